// ---- shared/rcl_pkg.sv ----
//==========================================================
// reclocker control constants
`default_nettype none
package rcl_pkg;
    //======================================================
    // clock and acquisition timing
    localparam int CLK_MHZ = 125;
    localparam int ACQ_AUTO_TYP_MS = 10;
    localparam int ACQ_AUTO_MAX_MS = 16;
    localparam int ACQ_FIXED_TYP_MS = 1;
    localparam int ACQ_FIXED_MAX_MS = 6;
    localparam int ACQ_AUTO_CYC = ACQ_AUTO_TYP_MS * 1000 * CLK_MHZ;
    localparam int ACQ_FIXED_CYC = ACQ_FIXED_TYP_MS * 1000 * CLK_MHZ;
    localparam int ACQ_W = 21;
    //======================================================
    // rate codes of the rate choice pins
    localparam logic [1:0] RATE_AUTO = 2'h0;
    localparam logic [1:0] RATE_SD270 = 2'h1;
    localparam logic [1:0] RATE_HD = 2'h2;
    //======================================================
    // bit periods of the scaled serial model, in clock cycles
    localparam int RUN_W = 8;
    localparam logic [RUN_W-1:0] BIT_SD143 = 8'h15;
    localparam logic [RUN_W-1:0] BIT_SD270 = 8'h0B;
    localparam logic [RUN_W-1:0] BIT_HD = 8'h02;
    localparam logic [RUN_W-1:0] RUN_MAX = 8'hFF;
    localparam logic [RUN_W-1:0] LOSS_CYC = 8'h80;
    localparam logic [5:0] WIN_TRANS = 6'h3F;
    //======================================================
    // register map and events
    localparam logic [1:0] REG_STATUS = 2'h0;
    localparam logic [1:0] REG_MASK = 2'h1;
    localparam logic [1:0] REG_STATE = 2'h2;
    localparam int EV_W = 3;
    localparam int EV_LOCK_RISE = 0;
    localparam int EV_LOCK_FALL = 1;
    localparam int EV_UNSUP = 2;
    localparam logic [EV_W-1:0] MASK_RST = 3'h0;
    //======================================================
    // types
    typedef enum logic [2:0] {
        CLS_NONE, CLS_SD143, CLS_SD270, CLS_HD, CLS_BAD
    } rcl_class_t;
    typedef enum logic [1:0] {
        LK_IDLE, LK_ACQ, LK_LOCK
    } rcl_lock_t;
endpackage : rcl_pkg
`default_nettype wire

// ---- src/rcl_reclocker.sv ----
// Function
// - recognise and retime the 143, 270, 1483 and 1485 Mbps rates.
// - resample the chosen stream on the recovered bit clock when retiming.
// - route exactly one of four serial inputs to the retiming path.
// - input pick code is a binary index, 00 input zero to 11 three.
// - clock choose high gives bit clock, low gives data copy.
// - clock mode output rises once per data bit period.
// - clock rising edge lies 40 to 60 percent into the data bit.
// - silence input low mutes both serial outputs.
// - bypass with clock mode mutes the second output.
// - muted output holds true and complement legs opposite, static.
// - auto search mode raises lock within 16 ms, typically 10 ms.
// - fixed rate mode raises lock within 6 ms, typically 1 ms.
// - lock indicator high only with data present and loop locked.
// - bypass pin or unlocked or unsupported rate skips retiming.
// - rate choice 00 auto search, 01 fixes 270, 10 fixes HD.
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module rcl_reclocker #(
    parameter int ACQ_AUTO = rcl_pkg::ACQ_AUTO_CYC,
    parameter int ACQ_FIXED = rcl_pkg::ACQ_FIXED_CYC
) (
    input wire logic CLOCK_I,
    input wire logic NRST_I,
    input wire logic [3:0] SERIAL_INPUTS_I,
    input wire logic INPUT_PICK_LSB_I,
    input wire logic INPUT_PICK_MSB_I,
    input wire logic CLOCK_OUT_CHOOSE_I,
    input wire logic OUT_SILENCE_N_I,
    input wire logic BYPASS_I,
    input wire logic [1:0] RATE_CHOICE_I,
    input wire logic [1:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [7:0] REG_RDATA_O,
    output logic IRQ_O,
    output logic PRIMARY_SERIAL_OUT_P_O,
    output logic PRIMARY_SERIAL_OUT_N_O,
    output logic SECOND_SERIAL_OUT_P_O,
    output logic SECOND_SERIAL_OUT_N_O,
    output logic LOCK_INDICATOR_O
);
    import rcl_pkg::*;

    //======================================================
    // helpers
    function automatic logic near(input logic [RUN_W-1:0] run,
                                  input logic [RUN_W-1:0] bitp);
        near = (run >= bitp - 8'h01) && (run <= bitp + 8'h01);
    endfunction : near

    function automatic rcl_class_t classify(input logic [RUN_W-1:0] r);
        if (near(r, BIT_HD)) begin
            classify = CLS_HD;
        end else if (near(r, BIT_SD270)) begin
            classify = CLS_SD270;
        end else if (near(r, BIT_SD143)) begin
            classify = CLS_SD143;
        end else begin
            classify = CLS_BAD;
        end
    endfunction : classify

    //======================================================
    // input pick and run measurement
    logic in_q, in_prev, edge_seen;
    logic [RUN_W-1:0] run_cnt, next_run_cnt;
    logic [RUN_W-1:0] run_len, next_run_len;
    logic [1:0] pick;
    logic present;

    assign pick = {INPUT_PICK_MSB_I, INPUT_PICK_LSB_I};
    assign edge_seen = in_q ^ in_prev;
    // a long quiet stretch means the source has gone away
    assign present = run_cnt < LOSS_CYC;

    always_comb begin
        next_run_cnt = run_cnt;
        next_run_len = run_len;
        if (edge_seen) begin
            // a run that began in silence is no bit and must not
            // set the shortest run, so it is held at the ceiling
            next_run_len = (run_cnt == RUN_MAX) ? RUN_MAX
                           : run_cnt + 8'h01;
            next_run_cnt = 8'h00;
        end else if (run_cnt != RUN_MAX) begin
            next_run_cnt = run_cnt + 8'h01;
        end
    end

    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            in_q <= 1'b0;
            in_prev <= 1'b0;
            run_cnt <= RUN_MAX;
            run_len <= RUN_MAX;
        end else begin
            in_q <= SERIAL_INPUTS_I[pick];
            in_prev <= in_q;
            run_cnt <= next_run_cnt;
            run_len <= next_run_len;
        end
    end

    //======================================================
    // rate detection over a window of transitions
    // the shortest run in the window is taken as one bit period
    logic [RUN_W-1:0] min_run, next_min_run;
    logic [5:0] trans, next_trans;
    logic edge_d;
    rcl_class_t cls, next_cls;

    always_comb begin
        next_min_run = min_run;
        next_trans = trans;
        next_cls = cls;
        if (!present) begin
            next_cls = CLS_NONE;
            next_trans = 6'h00;
            next_min_run = RUN_MAX;
        end else if (edge_d) begin
            if (trans == WIN_TRANS) begin
                next_cls = classify(min_run);
                next_trans = 6'h00;
                next_min_run = run_len;
            end else begin
                next_trans = trans + 6'h01;
                if (run_len < min_run) begin
                    next_min_run = run_len;
                end
            end
        end
    end

    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            min_run <= RUN_MAX;
            trans <= 6'h00;
            cls <= CLS_NONE;
            edge_d <= 1'b0;
        end else begin
            min_run <= next_min_run;
            trans <= next_trans;
            cls <= next_cls;
            edge_d <= edge_seen;
        end
    end

    //======================================================
    // lock acquisition
    rcl_lock_t lk, next_lk;
    logic [ACQ_W-1:0] acq, next_acq, acq_lim;
    logic mode_ok, lock_q, next_lock, unsup, next_unsup;

    always_comb begin
        case (RATE_CHOICE_I)
            RATE_AUTO: begin
                mode_ok = (cls == CLS_SD143) || (cls == CLS_SD270)
                          || (cls == CLS_HD);
            end
            RATE_SD270: begin
                mode_ok = cls == CLS_SD270;
            end
            RATE_HD: begin
                mode_ok = cls == CLS_HD;
            end
            default: begin
                mode_ok = 1'b0;
            end
        endcase
    end

    // fixed rates skip the search and so lock sooner
    assign acq_lim = (RATE_CHOICE_I == RATE_AUTO)
                     ? ACQ_W'(ACQ_AUTO - 1)
                     : ACQ_W'(ACQ_FIXED - 1);

    always_comb begin
        next_lk = lk;
        next_acq = acq;
        next_unsup = 1'b0;
        case (lk)
            LK_IDLE: begin
                next_acq = '0;
                if (edge_seen) begin
                    next_lk = LK_ACQ;
                end
            end
            LK_ACQ: begin
                if (!present) begin
                    next_lk = LK_IDLE;
                end else if (acq >= acq_lim) begin
                    next_acq = '0;
                    if (mode_ok) begin
                        next_lk = LK_LOCK;
                    end else begin
                        next_unsup = 1'b1;
                    end
                end else begin
                    next_acq = acq + ACQ_W'(1);
                end
            end
            LK_LOCK: begin
                if (!present || !mode_ok) begin
                    next_lk = LK_IDLE;
                end
            end
            default: begin
                next_lk = LK_IDLE;
            end
        endcase
        next_lock = next_lk == LK_LOCK;
    end

    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            lk <= LK_IDLE;
            acq <= '0;
            lock_q <= 1'b0;
            unsup <= 1'b0;
        end else begin
            lk <= next_lk;
            acq <= next_acq;
            lock_q <= next_lock;
            unsup <= next_unsup;
        end
    end

    //======================================================
    // recovered bit clock and retiming
    // phase restarts on every transition, like a bang-bang loop
    logic [4:0] phase, next_phase, per, half;
    logic retimed, next_retimed;

    always_comb begin
        case (cls)
            CLS_SD143: per = BIT_SD143[4:0];
            CLS_SD270: per = BIT_SD270[4:0];
            default: per = BIT_HD[4:0];
        endcase
    end
    assign half = {1'b0, per[4:1]};

    always_comb begin
        next_retimed = retimed;
        if (edge_seen || phase == per - 5'h01) begin
            next_phase = 5'h00;
        end else begin
            next_phase = phase + 5'h01;
        end
        if (phase == half) begin
            next_retimed = in_q;
        end
    end

    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            phase <= 5'h00;
            retimed <= 1'b0;
        end else begin
            phase <= next_phase;
            retimed <= next_retimed;
        end
    end

    //======================================================
    // output stage
    logic byp, data_bit, rclk, mute1, mute2, sec_bit;
    logic next_p1, next_n1, next_p2, next_n2;

    assign byp = BYPASS_I || !lock_q;
    assign data_bit = byp ? in_q : retimed;
    // retimed data moves at phase half+1, so the rise sits half a bit
    // later: phase 0 for odd periods, phase 1 for even ones
    assign rclk = per[0] ? (phase < half)
                  : (phase != 5'h00 && phase <= half);
    assign sec_bit = CLOCK_OUT_CHOOSE_I ? rclk : data_bit;
    assign mute1 = !OUT_SILENCE_N_I;
    assign mute2 = mute1 || (CLOCK_OUT_CHOOSE_I && byp);

    always_comb begin
        next_p1 = mute1 ? 1'b0 : data_bit;
        next_n1 = mute1 ? 1'b1 : !data_bit;
        next_p2 = mute2 ? 1'b0 : sec_bit;
        next_n2 = mute2 ? 1'b1 : !sec_bit;
    end

    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            PRIMARY_SERIAL_OUT_P_O <= 1'b0;
            PRIMARY_SERIAL_OUT_N_O <= 1'b1;
            SECOND_SERIAL_OUT_P_O <= 1'b0;
            SECOND_SERIAL_OUT_N_O <= 1'b1;
            LOCK_INDICATOR_O <= 1'b0;
        end else begin
            PRIMARY_SERIAL_OUT_P_O <= next_p1;
            PRIMARY_SERIAL_OUT_N_O <= next_n1;
            SECOND_SERIAL_OUT_P_O <= next_p2;
            SECOND_SERIAL_OUT_N_O <= next_n2;
            LOCK_INDICATOR_O <= next_lock;
        end
    end

    //======================================================
    // registers and interrupt
    logic [EV_W-1:0] status, next_status, mask, next_mask, ev;
    logic [7:0] next_rdata;

    always_comb begin
        ev = '0;
        ev[EV_LOCK_RISE] = next_lock && !lock_q;
        ev[EV_LOCK_FALL] = !next_lock && lock_q;
        ev[EV_UNSUP] = unsup;
        next_mask = mask;
        next_rdata = 8'h00;
        // a new event in the clearing read survives the clear
        next_status = status | ev;
        if (REG_RD_I && REG_ADDR_I == REG_STATUS) begin
            next_status = ev;
        end
        if (REG_WR_I && REG_ADDR_I == REG_MASK) begin
            next_mask = REG_WDATA_I[EV_W-1:0];
        end
        if (REG_RD_I) begin
            case (REG_ADDR_I)
                REG_STATUS: next_rdata = {5'h00, status};
                REG_MASK: next_rdata = {5'h00, mask};
                REG_STATE: next_rdata = {2'h0, cls, byp, present, lock_q};
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            status <= '0;
            mask <= MASK_RST;
            REG_RDATA_O <= 8'h00;
            IRQ_O <= 1'b0;
        end else begin
            status <= next_status;
            mask <= next_mask;
            REG_RDATA_O <= next_rdata;
            IRQ_O <= |(next_status & next_mask);
        end
    end
endmodule : rcl_reclocker
`default_nettype wire

// ---- verif/rcl_reclocker_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module rcl_reclocker_bench;
    import rcl_pkg::*;
    // short acquisition, still longer than 64 transitions at SD143
    localparam int AA = 2400;
    localparam int AF = 1600;
    logic clk = 1'b0, nrst = 1'b0, en = 1'b0, choose = 1'b0;
    logic sil_n = 1'b1, byp = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [1:0] pick = 2'h0, rate = 2'h0, addr = 2'h0;
    logic [7:0] per = 8'h02, wdata = 8'h00, rdata, d;
    logic [3:0] sin;
    logic irq, pp, pn, sp, sn, lock, el;
    logic [31:0] seed = 32'h0000001B;
    logic [1:0] rt [7] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h1, 2'h3};
    logic [7:0] pt [7] = '{BIT_SD143, BIT_SD270, BIT_HD, BIT_SD270,
                           BIT_HD, BIT_HD, BIT_SD270};
    int fails = 0, samples_checked = 0, n, ns, np, nr;
    always #4 clk = ~clk;
    rcl_src src (.clk_i(clk), .nrst_i(nrst), .en_i(en), .per_i(per),
        .chan_i(pick), .line_o(sin));
    rcl_reclocker #(.ACQ_AUTO(AA), .ACQ_FIXED(AF)) dut (.CLOCK_I(clk),
        .NRST_I(nrst), .SERIAL_INPUTS_I(sin), .INPUT_PICK_LSB_I(pick[0]),
        .INPUT_PICK_MSB_I(pick[1]), .CLOCK_OUT_CHOOSE_I(choose),
        .OUT_SILENCE_N_I(sil_n), .BYPASS_I(byp), .RATE_CHOICE_I(rate),
        .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr),
        .REG_RD_I(rd), .REG_RDATA_O(rdata), .IRQ_O(irq),
        .PRIMARY_SERIAL_OUT_P_O(pp), .PRIMARY_SERIAL_OUT_N_O(pn),
        .SECOND_SERIAL_OUT_P_O(sp), .SECOND_SERIAL_OUT_N_O(sn),
        .LOCK_INDICATOR_O(lock));
    //======================================================
    // expectations
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    function automatic logic ex_lock(input logic [1:0] r, input logic [7:0] p);
        return r == RATE_AUTO || (r == RATE_SD270 && p == BIT_SD270) ||
            (r == RATE_HD && p == BIT_HD);
    endfunction : ex_lock
    function automatic logic [7:0] ex_state(input logic [7:0] p);
        logic [2:0] c;
        c = (p == BIT_HD) ? 3'h3 : (p == BIT_SD270) ? 3'h2 : 3'h1;
        return {2'h0, c, 3'h3};
    endfunction : ex_state
    //======================================================
    // tasks
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask : chk
    task wr_reg(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task rd_reg(input logic [1:0] a, output logic [7:0] v);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : rd_reg
    task edges(input int w, output int cs, output int cp, output int cr);
        logic a, b, c;
        cs = 0; cp = 0; cr = 0;
        @(posedge clk);
        #1 a = sin[pick]; b = pp; c = sp;
        repeat (w) begin
            @(posedge clk);
            #1 cs += (sin[pick] != a); cp += (pp != b); cr += (sp && !c);
            a = sin[pick]; b = pp; c = sp;
        end
    endtask : edges
    task wait_lock;
        n = 0;
        while (lock !== 1'b1 && n < AA + 800) begin
            @(posedge clk);
            n++;
        end
        #1;
    endtask : wait_lock
    task results;
        $display("checked %0d, failed %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results
    initial begin
        #600000;
        fails++;
        results();
    end
    //======================================================
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        #1 chk({pp, pn, sp, sn, lock, irq}, 16'h0014);
        wr_reg(REG_MASK, {seed[7:3], 3'h1});
        rd_reg(REG_MASK, d);
        chk(d, 16'h0001);
        rd_reg(2'h3, d);
        chk(d, 16'h0000);
        for (int i = 0; i < 7; i++) begin
            seed = xs(seed);
            @(posedge clk);
            pick <= seed[1:0]; rate <= rt[i]; per <= pt[i];
            en <= 1'b1;
            rd_reg(REG_STATUS, d);
            el = ex_lock(rt[i], pt[i]);
            wait_lock();
            chk(lock, el);
            if (el) begin
                chk(irq, 1'b1);
                rd_reg(REG_STATUS, d);
                chk(d, 16'h0001);
                @(posedge clk);
                #1 chk(irq, 1'b0);
                rd_reg(REG_STATE, d);
                chk(d, ex_state(pt[i]));
                edges(200, ns, np, nr);
                chk(ns > np + 2 || np > ns + 2, 1'b0);
                @(posedge clk);
                choose <= 1'b1;
                repeat (2) @(posedge clk);
                edges(220, ns, np, nr);
                n = 220 / int'(pt[i]);
                chk(nr > n + 1 || nr + 1 < n, 1'b0);
            end else begin
                rd_reg(REG_STATUS, d);
                chk(d[2], 1'b1);
            end
            @(posedge clk);
            choose <= 1'b0;
            en <= 1'b0;
            repeat (140) @(posedge clk);
            #1 chk(lock, 1'b0);
            if (el) begin
                chk(irq, 1'b0);
                rd_reg(REG_STATUS, d);
                chk(d, 16'h0002);
            end
        end
        @(posedge clk);
        rate <= RATE_AUTO; per <= BIT_HD; en <= 1'b1;
        wait_lock();
        chk(lock, 1'b1);
        @(posedge clk);
        byp <= 1'b1; choose <= 1'b1;
        repeat (20) @(posedge clk);
        #1 chk({sp, sn}, 16'h0001);
        @(posedge clk);
        sil_n <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk({pp, pn, sp, sn}, 16'h0005);
        repeat (5) @(posedge clk);
        #1 chk({pp, pn, sp, sn}, 16'h0005);
        @(posedge clk);
        sil_n <= 1'b1; byp <= 1'b0; choose <= 1'b0;
        repeat (4) @(posedge clk);
        results();
    end
endmodule : rcl_reclocker_bench
`default_nettype wire

// ---- verif/rcl_reclocker_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
module rcl_reclocker_monitor #(
    parameter int ACQ_AUTO = 2400,
    parameter int ACQ_FIXED = 1600
) (
    input wire logic CLOCK_I,
    input wire logic NRST_I,
    input wire logic [3:0] SERIAL_INPUTS_I,
    input wire logic INPUT_PICK_LSB_I,
    input wire logic INPUT_PICK_MSB_I,
    input wire logic CLOCK_OUT_CHOOSE_I,
    input wire logic OUT_SILENCE_N_I,
    input wire logic BYPASS_I,
    input wire logic [1:0] RATE_CHOICE_I,
    input wire logic REG_RD_I,
    input wire logic [7:0] REG_RDATA_O,
    input wire logic PRIMARY_SERIAL_OUT_P_O,
    input wire logic PRIMARY_SERIAL_OUT_N_O,
    input wire logic SECOND_SERIAL_OUT_P_O,
    input wire logic SECOND_SERIAL_OUT_N_O,
    input wire logic LOCK_INDICATOR_O
);
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (!NRST_I);
    //======================================================
    // helper: quiet time and time since first transition
    logic pick;
    logic prev;
    logic [7:0] quiet;
    logic [31:0] acq;
    logic clk_ok;
    int lim;
    assign clk_ok = CLOCK_OUT_CHOOSE_I && !BYPASS_I && OUT_SILENCE_N_I &&
        LOCK_INDICATOR_O;
    assign pick = SERIAL_INPUTS_I[{INPUT_PICK_MSB_I, INPUT_PICK_LSB_I}];
    assign lim = (RATE_CHOICE_I == 2'h0) ? ACQ_AUTO : ACQ_FIXED;
    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            prev <= 1'b0;
            quiet <= 8'hFF;
            acq <= 32'h00000000;
        end else begin
            prev <= pick;
            if (pick != prev) quiet <= 8'h00;
            else if (quiet != 8'hFF) quiet <= quiet + 8'h01;
            if (pick != prev && quiet >= 8'h80) acq <= 32'h00000001;
            else if (acq != 32'h00000000 && !LOCK_INDICATOR_O &&
                     acq != 32'hFFFFFFFF)
                acq <= acq + 32'h00000001;
        end
    end
    //======================================================
    // sequences
    sequence s_muted;
        !PRIMARY_SERIAL_OUT_P_O && PRIMARY_SERIAL_OUT_N_O &&
        !SECOND_SERIAL_OUT_P_O && SECOND_SERIAL_OUT_N_O;
    endsequence
    sequence s_bypass_run;
        (BYPASS_I && OUT_SILENCE_N_I)[*3];
    endsequence
    //======================================================
    // assertions
    a_lock_acq_time: assert property (
        $rose(LOCK_INDICATOR_O) |-> acq >= lim && acq <= lim + 8)
        else $error("lock rose outside acquisition window");
    a_lock_needs_data: assert property (
        quiet >= 8'h84 |-> !LOCK_INDICATOR_O)
        else $error("lock high without input data");
    a_rate_never_lock: assert property (
        RATE_CHOICE_I == 2'h3 |-> !$rose(LOCK_INDICATOR_O))
        else $error("lock rose in the no-lock rate code");
    a_mute_both: assert property (
        !OUT_SILENCE_N_I |=> s_muted)
        else $error("outputs not muted");
    a_mute_static: assert property (
        !OUT_SILENCE_N_I[*3] |-> $stable(PRIMARY_SERIAL_OUT_P_O) &&
        $stable(SECOND_SERIAL_OUT_P_O))
        else $error("muted output toggled");
    a_bypass_clk_mute: assert property (
        BYPASS_I && CLOCK_OUT_CHOOSE_I |=>
        !SECOND_SERIAL_OUT_P_O && SECOND_SERIAL_OUT_N_O)
        else $error("clock output not muted in bypass");
    a_bypass_copy: assert property (
        s_bypass_run |-> PRIMARY_SERIAL_OUT_P_O == $past(pick, 2) &&
        PRIMARY_SERIAL_OUT_N_O != PRIMARY_SERIAL_OUT_P_O)
        else $error("bypass data not passed through");
    a_second_copy: assert property (
        (!CLOCK_OUT_CHOOSE_I && OUT_SILENCE_N_I)[*2] |->
        SECOND_SERIAL_OUT_P_O == PRIMARY_SERIAL_OUT_P_O)
        else $error("second output is not a data copy");
    a_clock_mid_bit: assert property (
        $rose(SECOND_SERIAL_OUT_P_O) && $past(clk_ok) && $past(clk_ok, 2)
        |-> $stable(PRIMARY_SERIAL_OUT_P_O))
        else $error("clock rise coincides with a data change");
    a_rdata_idle: assert property (
        !REG_RD_I |=> REG_RDATA_O == 8'h00)
        else $error("read data outside read cycle");
endmodule : rcl_reclocker_monitor
bind rcl_reclocker rcl_reclocker_monitor #(
    .ACQ_AUTO(ACQ_AUTO), .ACQ_FIXED(ACQ_FIXED)) mon (
    .CLOCK_I(CLOCK_I), .NRST_I(NRST_I), .SERIAL_INPUTS_I(SERIAL_INPUTS_I),
    .INPUT_PICK_LSB_I(INPUT_PICK_LSB_I), .INPUT_PICK_MSB_I(INPUT_PICK_MSB_I),
    .CLOCK_OUT_CHOOSE_I(CLOCK_OUT_CHOOSE_I), .OUT_SILENCE_N_I(OUT_SILENCE_N_I),
    .BYPASS_I(BYPASS_I), .RATE_CHOICE_I(RATE_CHOICE_I), .REG_RD_I(REG_RD_I),
    .REG_RDATA_O(REG_RDATA_O), .LOCK_INDICATOR_O(LOCK_INDICATOR_O),
    .PRIMARY_SERIAL_OUT_P_O(PRIMARY_SERIAL_OUT_P_O),
    .PRIMARY_SERIAL_OUT_N_O(PRIMARY_SERIAL_OUT_N_O),
    .SECOND_SERIAL_OUT_P_O(SECOND_SERIAL_OUT_P_O),
    .SECOND_SERIAL_OUT_N_O(SECOND_SERIAL_OUT_N_O));
`default_nettype wire

// ---- verif/rcl_src.sv ----
`timescale 1ns/100ps
`default_nettype none
//======================================================
// serial source: one picked line carries data, the rest
// carry a slow square wave so a wrong pick misclassifies
module rcl_src (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic en_i,
    input wire logic [7:0] per_i,
    input wire logic [1:0] chan_i,
    output logic [3:0] line_o
);
    logic [7:0] ph;
    logic [2:0] nb;
    logic bit_v;
    logic [6:0] slow;
    logic [3:0] sel;
    assign sel = 4'h1 << chan_i;
    // idle lines stay static: no data means no transitions
    assign line_o = en_i ? (({4{bit_v}} & sel) | ({4{slow[6]}} & ~sel))
                         : 4'h0;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ph <= 8'h00;
            nb <= 3'h0;
            bit_v <= 1'b0;
            slow <= 7'h00;
        end else if (en_i) begin
            slow <= slow + 7'h01;
            if (ph >= per_i - 8'h01) begin
                ph <= 8'h00;
                nb <= nb + 3'h1;
                // mostly single bits, one doubled bit in eight
                bit_v <= (nb == 3'h7) ? bit_v : ~bit_v;
            end else begin
                ph <= ph + 8'h01;
            end
        end
    end
endmodule : rcl_src
`default_nettype wire
